// ===== verilog/gir_global_regs.sv
`timescale 1ns/100ps
// What this block does
// RULE1: Three read-only identification bytes at 0..2
// RULE2: Revision in upper nibble of byte three
// RULE3: Soft reset bit pulses data path, self-clears
// RULE4: Wake pin driven only when enable set
// RULE5: Polarity bit: zero low, one high active
// RULE6: Global bit 31 mirrors lookup unit request
// RULE7: Global bit 30 mirrors trigger/timestamp request
// RULE8: Global mask bits 31,30; one disables
// RULE9: Port summary bits 0..3 for ports 1..4
// RULE10: Port 5 summary at bit 6, rest reserved
// RULE11: Port mask bits match status positions
// RULE12: Port 5 mask at bit 6
// RULE13: Interrupt asserted when unmasked summary bit set
// RULE14: Summaries mirror sources; writes cannot clear
// RULE15: Big-endian bytes, each individually accessible
// RULE16: Host uses byte-wide sixteen-bit addressed access
module gir_global_regs #(
  parameter int         LOOKUP_SRC_W    = 4,        // Lookup unit detail lines
  parameter int         PTP_GPIO_SRC_W  = 2,        // Trigger/timestamp detail lines
  parameter int         PORT_SRC_W      = 4,        // Detail lines per port
  parameter int         SOFT_RST_LEN    = gir_pkg::SOFT_RST_CYCLES, // Pulse cycles
  parameter logic [7:0] CHIP_FIXED_CODE = 8'hA5,    // Arbitrary value
  parameter logic [7:0] CHIP_CODE_HIGH  = 8'h3C,    // Arbitrary value
  parameter logic [7:0] CHIP_CODE_LOW   = 8'h71,    // Arbitrary value
  parameter logic [3:0] REVISION        = 4'h1      // Arbitrary value
) (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            nrst,
  // Byte-wide management access
  input  wire logic [15:0]                     mgmt_addr,
  input  wire logic                            mgmt_wr,
  input  wire logic [7:0]                      mgmt_wdata,
  input  wire logic                            mgmt_rd,
  output logic [7:0]                           mgmt_rdata,
  output logic                                 mgmt_rvalid,
  // Detail interrupt sources
  input  wire logic [LOOKUP_SRC_W-1:0]         lookup_src,
  input  wire logic [PTP_GPIO_SRC_W-1:0]       ptp_gpio_src,
  input  wire logic [gir_pkg::NUM_PORTS*PORT_SRC_W-1:0] port_src,
  // Wake event request and pin
  input  wire logic                            wake_event_req,
  output logic                                 wake_event_pin,
  output logic                                 wake_event_pin_oe,
  // Data path reset and interrupt
  output logic                                 datapath_rst_n,
  output logic                                 irq_n
);

  // ************************************************************
  // Soft reset state machine types
  // ************************************************************
  typedef enum logic [1:0] {
    GIR_SR_IDLE = 2'b01, // Normal operation
    GIR_SR_HOLD = 2'b10  // Data path held in reset
  } gir_sr_state_t;

  localparam int CNT_W = $clog2(SOFT_RST_LEN + 1); // Pulse counter width

  // ************************************************************
  // Declarations
  // ************************************************************
  gir_sr_state_t          sr_state_reg;     // Soft reset state
  gir_sr_state_t          sr_state_next;
  logic [CNT_W-1:0]       sr_cnt_reg;       // Cycles left in pulse
  logic [CNT_W-1:0]       sr_cnt_next;
  logic                   wake_en_reg;      // Wake pin enable
  logic                   wake_en_next;
  logic                   wake_pol_reg;     // Wake pin polarity
  logic                   wake_pol_next;
  logic [1:0]             glb_dis_reg;      // Global mask [31],[30]
  logic [1:0]             glb_dis_next;
  logic [4:0]             port_dis_reg;     // Port masks, ports 1..5
  logic [4:0]             port_dis_next;
  logic [7:0]             rdata_reg;        // Read data
  logic [7:0]             rdata_next;
  logic                   rvalid_reg;       // Read data valid
  logic                   rvalid_next;
  logic                   pin_o_reg;        // Wake pin level
  logic                   pin_o_next;
  logic                   pin_oe_reg;       // Wake pin enable
  logic                   pin_oe_next;
  logic                   irq_n_reg;        // Interrupt output
  logic                   irq_n_next;
  logic                   in_group;         // Address is in this group
  logic [4:0]             byte_ofs;         // Low address bits
  logic                   lookup_sum;       // Lookup unit summary
  logic                   lookup_act;
  logic                   ptp_sum;          // Trigger/timestamp summary
  logic                   ptp_act;
  logic [4:0]             port_sum;         // Per-port summaries
  logic [4:0]             port_act;
  logic [31:0]            glb_sum_word;     // Global summary word
  logic [31:0]            glb_dis_word;     // Global mask word
  logic [31:0]            port_sum_word;    // Port summary word
  logic [31:0]            port_dis_word;    // Port mask word

  // ************************************************************
  // Address decode
  // ************************************************************
  // Port field zero and offsets below 0x20 belong here
  always_comb
  begin
    in_group = (mgmt_addr[15:5] == 11'h000); // see RULE16
    byte_ofs = mgmt_addr[4:0];
  end

  // ************************************************************
  // Summary slices
  // ************************************************************
  // Lookup unit summary
  gir_irq_slice #(
    .SRC_W (LOOKUP_SRC_W)
  ) u_lookup_slice (
    .src_req     (lookup_src),
    .disable_bit (glb_dis_reg[1]),
    .summary     (lookup_sum),
    .active      (lookup_act)
  );

  // Trigger output and timestamp summary
  gir_irq_slice #(
    .SRC_W (PTP_GPIO_SRC_W)
  ) u_ptp_slice (
    .src_req     (ptp_gpio_src),
    .disable_bit (glb_dis_reg[0]),
    .summary     (ptp_sum),
    .active      (ptp_act)
  );

  // One slice per port
  for (genvar p = 0; p < gir_pkg::NUM_PORTS; p++)
  begin : g_port
    gir_irq_slice #(
      .SRC_W (PORT_SRC_W)
    ) u_port_slice (
      .src_req     (port_src[p*PORT_SRC_W +: PORT_SRC_W]),
      .disable_bit (port_dis_reg[p]),
      .summary     (port_sum[p]),
      .active      (port_act[p])
    );
  end

  // ************************************************************
  // Register words, reserved bits zero
  // ************************************************************
  always_comb
  begin
    glb_sum_word  = 32'h0000_0000;
    glb_dis_word  = 32'h0000_0000;
    port_sum_word = 32'h0000_0000;
    port_dis_word = 32'h0000_0000;
    // Summaries are live mirrors of the sources
    glb_sum_word[gir_pkg::GLB_LOOKUP_BIT]   = lookup_sum;   // see RULE6 see RULE14
    glb_sum_word[gir_pkg::GLB_PTP_GPIO_BIT] = ptp_sum;      // see RULE7
    glb_dis_word[gir_pkg::GLB_LOOKUP_BIT]   = glb_dis_reg[1]; // see RULE8
    glb_dis_word[gir_pkg::GLB_PTP_GPIO_BIT] = glb_dis_reg[0];
    port_sum_word[3:0] = port_sum[3:0];                     // see RULE9
    port_sum_word[gir_pkg::PORT5_BIT] = port_sum[4];        // see RULE10
    port_dis_word[3:0] = port_dis_reg[3:0];                 // see RULE11
    port_dis_word[gir_pkg::PORT5_BIT] = port_dis_reg[4];    // see RULE12
  end

  // ************************************************************
  // Register writes and soft reset control
  // ************************************************************
  always_comb
  begin
    wake_en_next  = wake_en_reg;
    wake_pol_next = wake_pol_reg;
    glb_dis_next  = glb_dis_reg;
    port_dis_next = port_dis_reg;
    sr_state_next = sr_state_reg;
    sr_cnt_next   = sr_cnt_reg;
    // Soft reset pulse counts down, then returns to idle
    unique case (sr_state_reg)
      GIR_SR_IDLE:
      begin
        sr_cnt_next = '0;
      end
      GIR_SR_HOLD:
      begin
        if (sr_cnt_reg <= CNT_W'(1))
        begin
          sr_state_next = GIR_SR_IDLE; // see RULE3
          sr_cnt_next   = '0;
        end
        else
        begin
          sr_cnt_next = sr_cnt_reg - CNT_W'(1);
        end
      end
    endcase
    // Byte writes; identification and summaries ignore them
    if (mgmt_wr && in_group)
    begin
      unique case ({11'h000, byte_ofs})
        gir_pkg::OFS_REV_SOFT_RST:
        begin
          // Writing one starts or restarts the pulse
          if (mgmt_wdata[gir_pkg::SOFT_RST_BIT])
          begin
            sr_state_next = GIR_SR_HOLD;        // see RULE3
            sr_cnt_next   = CNT_W'(SOFT_RST_LEN);
          end
        end
        gir_pkg::OFS_WAKE_PIN_CTRL:
        begin
          wake_en_next  = mgmt_wdata[gir_pkg::WAKE_EN_BIT];  // see RULE4
          wake_pol_next = mgmt_wdata[gir_pkg::WAKE_POL_BIT]; // see RULE5
        end
        gir_pkg::OFS_GLOBAL_IRQ_DIS:
        begin
          // Most significant byte holds bits 31 and 30
          glb_dis_next = mgmt_wdata[7:6];                 // see RULE8 see RULE15
        end
        gir_pkg::OFS_PORT_IRQ_DIS + 16'h0003:
        begin
          // Least significant byte holds the port masks
          port_dis_next = {mgmt_wdata[gir_pkg::PORT5_BIT], mgmt_wdata[3:0]}; // see RULE11 see RULE12
        end
        default:
        begin
          // Read-only or unused byte: no effect
        end
      endcase
    end
  end

  // ************************************************************
  // Read data path
  // ************************************************************
  // One-cycle latency; bytes picked big-endian from each word
  always_comb
  begin
    rvalid_next = mgmt_rd;
    rdata_next  = rdata_reg;
    if (mgmt_rd)
    begin
      rdata_next = 8'h00;
      if (in_group)
      begin
        unique case ({11'h000, byte_ofs})
          gir_pkg::OFS_CHIP_CODE_BYTE0: rdata_next = CHIP_FIXED_CODE; // see RULE1
          gir_pkg::OFS_CHIP_CODE_HIGH:  rdata_next = CHIP_CODE_HIGH;  // see RULE1
          gir_pkg::OFS_CHIP_CODE_LOW:   rdata_next = CHIP_CODE_LOW;   // see RULE1
          gir_pkg::OFS_REV_SOFT_RST:
          begin
            // Revision, reserved zeros, soft reset busy flag
            rdata_next = {REVISION, 3'h0, (sr_state_reg == GIR_SR_HOLD)}; // see RULE2 see RULE3
          end
          gir_pkg::OFS_WAKE_PIN_CTRL:
          begin
            rdata_next = {6'h00, wake_en_reg, wake_pol_reg};
          end
          default:
          begin
            // Multi-byte words, most significant byte first
            unique case (byte_ofs[4:2])
              3'h4:    rdata_next = glb_sum_word[8*(3-byte_ofs[1:0]) +: 8];  // see RULE15
              3'h5:    rdata_next = glb_dis_word[8*(3-byte_ofs[1:0]) +: 8];
              3'h6:    rdata_next = port_sum_word[8*(3-byte_ofs[1:0]) +: 8];
              3'h7:    rdata_next = port_dis_word[8*(3-byte_ofs[1:0]) +: 8];
              default: rdata_next = 8'h00;
            endcase
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Outputs: wake pin and interrupt
  // ************************************************************
  always_comb
  begin
    // Asserted level follows polarity; idle is the opposite level
    pin_o_next  = wake_pol_reg ? wake_event_req : ~wake_event_req; // see RULE5
    pin_oe_next = wake_en_reg;                                     // see RULE4
    // Any unmasked summary drives the interrupt low
    irq_n_next  = ~(lookup_act | ptp_act | (|port_act));           // see RULE13
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sr_state_reg <= GIR_SR_IDLE;
      sr_cnt_reg   <= '0;
      wake_en_reg  <= gir_pkg::RST_WAKE_EN;
      wake_pol_reg <= gir_pkg::RST_WAKE_POL;
      glb_dis_reg  <= gir_pkg::RST_GLOBAL_DIS;
      port_dis_reg <= gir_pkg::RST_PORT_DIS;
      rdata_reg    <= 8'h00;
      rvalid_reg   <= 1'b0;
      pin_o_reg    <= 1'b1;
      pin_oe_reg   <= 1'b0;
      irq_n_reg    <= 1'b1;
    end
    else
    begin
      sr_state_reg <= sr_state_next;
      sr_cnt_reg   <= sr_cnt_next;
      wake_en_reg  <= wake_en_next;
      wake_pol_reg <= wake_pol_next;
      glb_dis_reg  <= glb_dis_next;
      port_dis_reg <= port_dis_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      pin_o_reg    <= pin_o_next;
      pin_oe_reg   <= pin_oe_next;
      irq_n_reg    <= irq_n_next;
    end
  end

  // ************************************************************
  // Port drivers
  // ************************************************************
  always_comb
  begin
    mgmt_rdata        = rdata_reg;
    mgmt_rvalid       = rvalid_reg;
    wake_event_pin    = pin_o_reg;
    wake_event_pin_oe = pin_oe_reg;
    datapath_rst_n    = (sr_state_reg != GIR_SR_HOLD); // see RULE3
    irq_n             = irq_n_reg;
  end

endmodule : gir_global_regs

// ===== verilog/gir_pkg.sv
// ************************************************************
// Global identification, reset and interrupt summary constants
// ************************************************************
package gir_pkg;

  // ************************************************************
  // Byte offsets in the global register space
  // ************************************************************
  localparam logic [15:0] OFS_CHIP_CODE_BYTE0 = 16'h0000; // Fixed code byte
  localparam logic [15:0] OFS_CHIP_CODE_HIGH  = 16'h0001; // Chip code, high byte
  localparam logic [15:0] OFS_CHIP_CODE_LOW   = 16'h0002; // Chip code, low byte
  localparam logic [15:0] OFS_REV_SOFT_RST    = 16'h0003; // Revision and soft reset
  localparam logic [15:0] OFS_WAKE_PIN_CTRL   = 16'h0006; // Wake pin control
  localparam logic [15:0] OFS_GLOBAL_IRQ_SUM  = 16'h0010; // Global summary, MSB byte
  localparam logic [15:0] OFS_GLOBAL_IRQ_DIS  = 16'h0014; // Global mask, MSB byte
  localparam logic [15:0] OFS_PORT_IRQ_SUM    = 16'h0018; // Port summary, MSB byte
  localparam logic [15:0] OFS_PORT_IRQ_DIS    = 16'h001C; // Port mask, MSB byte

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int REV_LSB          = 4;  // Revision nibble 7:4
  localparam int SOFT_RST_BIT     = 0;  // Self-clearing soft reset
  localparam int WAKE_EN_BIT      = 1;  // Wake pin output enable
  localparam int WAKE_POL_BIT     = 0;  // Wake pin polarity
  localparam int GLB_LOOKUP_BIT   = 31; // Lookup unit summary
  localparam int GLB_PTP_GPIO_BIT = 30; // Trigger/timestamp summary
  localparam int PORT5_BIT        = 6;  // External MAC port summary
  localparam int NUM_PORTS        = 5;  // Logical ports 1..5

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic       RST_WAKE_EN    = 1'b0; // Pin disabled
  localparam logic       RST_WAKE_POL   = 1'b0; // Active low
  localparam logic [1:0] RST_GLOBAL_DIS = 2'h0; // All enabled
  localparam logic [4:0] RST_PORT_DIS   = 5'h00; // All enabled

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 10;  // core_clk period
  localparam int SOFT_RST_NS     = 160; // Data path reset pulse length
  localparam int SOFT_RST_CYCLES =
    (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Rounded up

endpackage : gir_pkg

// ===== verilog/gir_irq_slice.sv
`timescale 1ns/100ps
// ************************************************************
// One summary source: OR of detail requests, gated by a mask
// ************************************************************
module gir_irq_slice #(
  parameter int SRC_W = 1 // Number of detail request lines
) (
  // Detail requests and mask
  input  wire logic [SRC_W-1:0] src_req,
  input  wire logic             disable_bit,
  // Summary results
  output logic                  summary,
  output logic                  active
);

  // ************************************************************
  // Summary and gated request
  // ************************************************************
  always_comb
  begin
    summary = |src_req;
    active  = summary & ~disable_bit;
  end

endmodule : gir_irq_slice

// ===== tb/gir_global_regs_props.sv
`timescale 1ns/100ps
// ************************************************************
// Checker for the global register group
// ************************************************************
module gir_global_regs_props #(
  parameter int LOOKUP_SRC_W   = 4,  // Lookup detail lines
  parameter int PTP_GPIO_SRC_W = 2,  // Trigger detail lines
  parameter int PORT_SRC_W     = 4,  // Lines per port
  parameter int SOFT_RST_LEN   = 16  // Pulse cycles
) (
  // Clock and reset
  input wire logic                                     core_clk,
  input wire logic                                     nrst,
  // Management access
  input wire logic [15:0]                              mgmt_addr,
  input wire logic                                     mgmt_wr,
  input wire logic [7:0]                               mgmt_wdata,
  input wire logic                                     mgmt_rd,
  input wire logic [7:0]                               mgmt_rdata,
  input wire logic                                     mgmt_rvalid,
  // Sources
  input wire logic [LOOKUP_SRC_W-1:0]                  lookup_src,
  input wire logic [PTP_GPIO_SRC_W-1:0]                ptp_gpio_src,
  input wire logic [gir_pkg::NUM_PORTS*PORT_SRC_W-1:0] port_src,
  // Pins
  input wire logic                                     wake_event_req,
  input wire logic                                     wake_event_pin,
  input wire logic                                     wake_event_pin_oe,
  input wire logic                                     datapath_rst_n,
  input wire logic                                     irq_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic [7:0] glb_byte;   // Expected global summary byte
  logic [7:0] port_byte;  // Expected port summary byte
  int         since_reg;  // Cycles since soft reset write
  int         since_next; // Next count

  // Expected summaries and soft reset age
  always_comb
  begin
    glb_byte  = {|lookup_src, |ptp_gpio_src, 6'h00};
    port_byte = 8'h00;
    for (int p = 0; p < 5; p++)
    begin
      port_byte[(p == 4) ? 6 : p] = |port_src[p*PORT_SRC_W +: PORT_SRC_W];
    end
    if (mgmt_wr && mgmt_addr == 16'h0003 && mgmt_wdata[0])
      since_next = 1;
    else
      since_next = (since_reg > SOFT_RST_LEN) ? since_reg : since_reg + 1;
  end

  // Age register, saturates past the pulse
  always_ff @(posedge core_clk)
  begin
    since_reg <= nrst ? since_next : SOFT_RST_LEN + 1;
  end

  // Wake control write followed by a quiet cycle
  sequence wake_wr_s;
    mgmt_wr && mgmt_addr == 16'h0006;
  endsequence
  sequence wake_settled_s;
    wake_wr_s ##1 !(mgmt_wr && mgmt_addr == 16'h0006);
  endsequence

  rvalid_rise_a: assert property (mgmt_rd |=> mgmt_rvalid)
    else $error("read not answered next cycle");
  rvalid_idle_a: assert property (!mgmt_rd |=> !mgmt_rvalid)
    else $error("answer without read");
  rev_byte_a: assert property (mgmt_rd && mgmt_addr == 16'h0003 |=>
    mgmt_rdata[3:0] == {3'h0, !$past(datapath_rst_n)})
    else $error("revision byte low bits wrong");
  glb_sum_a: assert property (mgmt_rd && mgmt_addr == 16'h0010 |=>
    mgmt_rdata == $past(glb_byte))
    else $error("global summary byte wrong");
  port_sum_a: assert property (mgmt_rd && mgmt_addr == 16'h001B |=>
    mgmt_rdata == $past(port_byte))
    else $error("port summary byte wrong");
  unmapped_read_a: assert property (mgmt_rd && mgmt_addr[15:5] != 11'h000 |=>
    mgmt_rdata == 8'h00)
    else $error("unmapped read not zero");
  wake_oe_a: assert property (wake_settled_s |=>
    wake_event_pin_oe == $past(mgmt_wdata[1], 2))
    else $error("wake enable not applied");
  wake_pol_a: assert property (wake_settled_s |=> !wake_event_pin_oe ||
    wake_event_pin == ($past(wake_event_req) ~^ $past(mgmt_wdata[0], 2)))
    else $error("wake polarity wrong");
  srst_len_a: assert property (datapath_rst_n == (since_reg > SOFT_RST_LEN))
    else $error("soft reset pulse wrong");
  irq_idle_a: assert property (lookup_src == '0 && ptp_gpio_src == '0 &&
    port_src == '0 |=> irq_n)
    else $error("interrupt without source");
endmodule : gir_global_regs_props

bind gir_global_regs gir_global_regs_props #(
  .LOOKUP_SRC_W  (LOOKUP_SRC_W),
  .PTP_GPIO_SRC_W(PTP_GPIO_SRC_W),
  .PORT_SRC_W    (PORT_SRC_W),
  .SOFT_RST_LEN  (SOFT_RST_LEN)
) i_props (
  .core_clk, .nrst, .mgmt_addr, .mgmt_wr, .mgmt_wdata, .mgmt_rd, .mgmt_rdata,
  .mgmt_rvalid, .lookup_src, .ptp_gpio_src, .port_src, .wake_event_req,
  .wake_event_pin, .wake_event_pin_oe, .datapath_rst_n, .irq_n
);

// ===== tb/gir_global_regs_tb.sv
`timescale 1ns/100ps
// ************************************************************
// Self-checking bench for the global register group
// ************************************************************
module gir_global_regs_tb;
  localparam int         RST_LEN = 4;     // Shortened pulse
  localparam int         PW      = 4;     // Lines per port
  localparam logic [7:0] ID0     = 8'h5A; // Arbitrary value
  localparam logic [7:0] ID1     = 8'hC3; // Arbitrary value
  localparam logic [7:0] ID2     = 8'h17; // Arbitrary value
  localparam logic [3:0] REV     = 4'h2;  // Arbitrary value

  logic        core_clk       = 1'b0;
  logic        nrst           = 1'b0;
  logic [15:0] mgmt_addr      = 16'h0000;
  logic        mgmt_wr        = 1'b0;
  logic [7:0]  mgmt_wdata     = 8'h00;
  logic        mgmt_rd        = 1'b0;
  logic [3:0]  lookup_src     = 4'h0;
  logic [1:0]  ptp_gpio_src   = 2'h0;
  logic [19:0] port_src       = 20'h00000;
  logic        wake_event_req = 1'b0;
  logic [7:0]  mgmt_rdata;   // Read byte
  logic        mgmt_rvalid;  // Read answer
  logic        pin_o;        // Wake pin level
  logic        pin_oe;       // Wake pin enable
  logic        dp_rst_n;     // Data path reset
  logic        irq_n;        // Interrupt
  int          err_total    = 0;
  int          total_checks = 0;

  gir_global_regs #(
    .PORT_SRC_W(PW), .SOFT_RST_LEN(RST_LEN), .CHIP_FIXED_CODE(ID0),
    .CHIP_CODE_HIGH(ID1), .CHIP_CODE_LOW(ID2), .REVISION(REV)
  ) i_dut (
    .core_clk, .nrst, .mgmt_addr, .mgmt_wr, .mgmt_wdata, .mgmt_rd, .mgmt_rdata,
    .mgmt_rvalid, .lookup_src, .ptp_gpio_src, .port_src, .wake_event_req,
    .wake_event_pin(pin_o), .wake_event_pin_oe(pin_oe),
    .datapath_rst_n(dp_rst_n), .irq_n
  );

  // Clock, 10 ns period
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    mgmt_addr  = a;
    mgmt_wdata = d;
    mgmt_wr    = 1'b1;
    tick(1);
    mgmt_wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    mgmt_addr = a;
    mgmt_rd   = 1'b1;
    tick(1);
    mgmt_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, mgmt_rvalid});
    chk($sformatf("byte %h", a), exp, mgmt_rdata);
    tick(1);
  endtask : rdc

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_vals;
    chk("oe", 8'h00, {7'h00, pin_oe});
    chk("dp", 8'h01, {7'h00, dp_rst_n});
    chk("irq", 8'h01, {7'h00, irq_n});
    rdc(16'h0006, 8'h00);
    for (int a = 16; a < 32; a++)
      rdc(16'(a), 8'h00);
  endtask : t_reset_vals

  task automatic t_ids;
    logic [7:0] exp [0:3];
    exp = '{ID0, ID1, ID2, {REV, 4'h0}};
    for (int i = 0; i < 4; i++)
    begin
      wr(16'(i), 8'hFE);
      rdc(16'(i), exp[i]);
    end
    rdc(16'h0020, 8'h00);
    rdc(16'h0100, 8'h00);
  endtask : t_ids

  task automatic t_wake;
    for (int v = 0; v < 8; v++)
    begin
      wake_event_req = v[2];
      wr(16'h0006, 8'hFC | 8'(v[1:0]));
      tick(1);
      rdc(16'h0006, 8'(v[1:0]));
      chk("oe", {7'h00, v[1]}, {7'h00, pin_oe});
      if (v[1])
        chk("pin", {7'h00, v[2] ~^ v[0]}, {7'h00, pin_o});
    end
    wr(16'h0006, 8'h00);
  endtask : t_wake

  task automatic t_soft_reset;
    int n;
    n = 0;
    wr(16'h0014, 8'hC0);
    mgmt_addr  = 16'h0003;
    mgmt_wdata = 8'h01;
    mgmt_wr    = 1'b1;
    tick(1);
    mgmt_wr = 1'b0;
    while (!dp_rst_n && n < 100)
    begin
      n++;
      tick(1);
    end
    chk("pulse", 8'(RST_LEN), 8'(n));
    wr(16'h0003, 8'h01);
    rdc(16'h0003, {REV, 4'h1});
    tick(RST_LEN);
    rdc(16'h0003, {REV, 4'h0});
    rdc(16'h0014, 8'hC0);
    wr(16'h0014, 8'h00);
  endtask : t_soft_reset

  task automatic t_global_irq;
    lookup_src = 4'h4;
    tick(2);
    rdc(16'h0010, 8'h80);
    chk("irq", 8'h00, {7'h00, irq_n});
    ptp_gpio_src = 2'h2;
    wr(16'h0014, 8'h80);
    rdc(16'h0010, 8'hC0);
    chk("irq", 8'h00, {7'h00, irq_n});
    wr(16'h0014, 8'hC0);
    tick(1);
    chk("irq", 8'h01, {7'h00, irq_n});
    wr(16'h0010, 8'h00);
    rdc(16'h0010, 8'hC0);
    rdc(16'h0013, 8'h00);
    lookup_src   = 4'h0;
    ptp_gpio_src = 2'h0;
    wr(16'h0014, 8'h00);
    tick(1);
    chk("irq", 8'h01, {7'h00, irq_n});
  endtask : t_global_irq

  task automatic t_port_irq;
    int b;
    for (int p = 0; p < 5; p++)
    begin
      b        = (p == 4) ? 6 : p;
      port_src = 20'h00001 << (p * PW + p % PW);
      tick(2);
      rdc(16'h001B, 8'h01 << b);
      rdc(16'h001A, 8'h00);
      chk("irq", 8'h00, {7'h00, irq_n});
      wr(16'h001F, 8'h01 << b);
      rdc(16'h001F, 8'h01 << b);
      chk("irq", 8'h01, {7'h00, irq_n});
      wr(16'h001F, 8'h00);
    end
    port_src = 20'h00000;
    wr(16'h001F, 8'hFF);
    rdc(16'h001F, 8'h4F);
    wr(16'h001F, 8'h00);
  endtask : t_port_irq

  // Reset in mid-run returns control and masks to defaults
  task automatic t_mid_reset;
    wr(16'h0006, 8'h03);
    wr(16'h0014, 8'hC0);
    wr(16'h001F, 8'h4F);
    nrst = 1'b0;
    tick(10);
    nrst = 1'b1;
    chk("oe", 8'h00, {7'h00, pin_oe});
    rdc(16'h0006, 8'h00);
    rdc(16'h0014, 8'h00);
    rdc(16'h001F, 8'h00);
  endtask : t_mid_reset

  // Watchdog against a hang
  initial
  begin
    #200000;
    err_total++;
    print_verdict;
  end

  // Main sequence
  initial
  begin
    tick(10);
    nrst = 1'b1;
    t_reset_vals;
    t_ids;
    t_wake;
    t_soft_reset;
    t_global_irq;
    t_port_irq;
    t_mid_reset;
    print_verdict;
  end
endmodule : gir_global_regs_tb
